// file: ebps_pkg.sv
// package with register map, field positions and carrier types for the pin sharing block
package ebps_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] EBPS_BUS_CONTROL_OFS   = 8'h00;
   localparam logic [7:0] EBPS_PORT_B_PER_OFS    = 8'h04;
   localparam logic [7:0] EBPS_PORT_B_DDR_OFS    = 8'h08;
   localparam logic [7:0] EBPS_PORT_B_DOUT_OFS   = 8'h0c;
   localparam logic [7:0] EBPS_PORT_B_PUR_OFS    = 8'h10;
   localparam logic [7:0] EBPS_PORT_F_PER_OFS    = 8'h14;
   localparam logic [7:0] EBPS_PORT_F_DDR_OFS    = 8'h18;
   localparam logic [7:0] EBPS_PORT_F_DOUT_OFS   = 8'h1c;
   localparam logic [7:0] EBPS_PORT_F_PUR_OFS    = 8'h20;
   localparam logic [7:0] EBPS_PIN_STATUS_OFS    = 8'h24;
   localparam int         EBPS_NUM_REGS          = 10;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int EBPS_IDLE_DRIVE_POS = 0;   // bus_idle_drive_bit in bus_control_register
   localparam int EBPS_PB_BIT0_POS    = 0;   // port B bit 0
   localparam int EBPS_PF_LOW_POS     = 9;   // data line 0 sits at port F bit 9
   localparam int EBPS_NUM_DATA       = 7;   // data lines 0..6
   localparam int EBPS_STAT_PB_POS    = 0;   // status: port_b_bit0 pin level
   localparam int EBPS_STAT_PF_POS    = 1;   // status: data line 0..6 pin levels in bits 1..7
   localparam int EBPS_STAT_AFN_POS   = 8;   // status: port_b_bit0 in address function
   localparam int EBPS_STAT_BUSY_POS  = 9;   // status: bus active

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic       EBPS_IDLE_DRIVE_RST = 1'h0;
   localparam logic [15:0] EBPS_PORT_F_PER_RST = 16'hfe00;  // data function on bits 9..15
   localparam logic [15:0] EBPS_ZERO16_RST     = 16'h0000;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } ebps_wb_req_type;

   typedef struct packed {
      logic        i;   // level seen at pin
      logic        o;   // level driven
      logic        oe_n; // low while driving
      logic        pu;  // internal pull-up enabled
   } ebps_pin_type;
endpackage

// file: ebps_sync_reg.sv
// one-bit register bank bit with write enable and reset value
`timescale 1ns/1ps
`default_nettype none
module ebps_sync_reg
   import ebps_pkg::*;
#(
   parameter logic RST_VAL = 1'h0
) (
   // clock and reset
   input  wire logic core_clk_in,
   input  wire logic reset_in,
   // write port
   input  wire logic wr_en_in,
   input  wire logic wr_dat_in,
   // stored value
   output var  logic val_out
);
   // ************************************************************
   // storage
   // ************************************************************
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         val_out <= RST_VAL;
      end else if (wr_en_in) begin
         val_out <= wr_dat_in;
      end
   end
endmodule
`default_nettype wire

// file: ebps_top.sv
// pin sharing of address line 16 and data lines 0..6 with port B bit 0 and port F bits 9..15
// ************************************************************
// Summary of operation
// - after reset, port_b_bit0 function chosen from boot, mode and security inputs
// - software may override port_b_bit0 function anytime via port_b_peripheral_enable
// - idle bus floats address_line_16 and controls unless bus_idle_drive_bit set
// - idle bus floats data lines 0..6 under the same bus_idle_drive_bit
// - port_b_pullup_control bit 0 set disables port_b_bit0 pull-up
// - reset gives data lines 0..6 the memory data function
// - in port function, port F bits 9..15 each input or output independently
// - port_f_pullup_control bit 9+n set disables data line n pull-up
// - port_b_bit0 in port function is software input or output
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
module ebps_top
   import ebps_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   // wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [31:0] wb_dat_in,
   output var  logic [31:0] wb_dat_out,
   output var  logic        wb_ack_out,
   // reset-time selection straps
   input  wire logic        external_boot_select_in,
   input  wire logic        memory_interface_mode_select_in,
   input  wire logic        flash_secure_in,
   // memory interface side
   input  wire logic        mif_bus_active_in,
   input  wire logic        mif_addr16_in,
   input  wire logic        mif_data_oe_in,
   input  wire logic [6:0]  mif_data_in,
   output var  logic [6:0]  mif_data_out,
   output var  logic        mif_ctrl_float_out,
   // pins: port_b_bit0 / address_line_16
   input  wire logic        port_b_bit0_pin_in,
   output var  logic        port_b_bit0_pin_out,
   output var  logic        port_b_bit0_pin_oe_n_out,
   output var  logic        port_b_bit0_pullup_out,
   // pins: data lines 0..6 / port F bits 9..15
   input  wire logic [6:0]  data_line_pin_in,
   output var  logic [6:0]  data_line_pin_out,
   output var  logic [6:0]  data_line_pin_oe_n_out,
   output var  logic [6:0]  data_line_pullup_out
);
   // ************************************************************
   // control state
   // ************************************************************
   logic        idle_drive_q;
   logic        pb_per_q;
   logic        pb_ddr_q;
   logic        pb_dout_q;
   logic        pb_pur_q;
   logic [6:0]  pf_per_q;
   logic [6:0]  pf_ddr_q;
   logic [6:0]  pf_dout_q;
   logic [6:0]  pf_pur_q;
   logic        strap_pend_q;
   logic        strap_pend_d;
   logic [31:0] rd_dat_d;
   logic        first_q;

   // ************************************************************
   // bus decode
   // ************************************************************
   wire logic       wb_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire logic       wb_wr    = wb_req & wb_we_in;
   wire logic       wr_lo    = wb_wr & wb_sel_in[0];
   wire logic       wr_hi    = wb_wr & wb_sel_in[1];
   wire logic       sel_bc   = (wb_adr_in == EBPS_BUS_CONTROL_OFS);
   wire logic       sel_bper = (wb_adr_in == EBPS_PORT_B_PER_OFS);
   wire logic       sel_bddr = (wb_adr_in == EBPS_PORT_B_DDR_OFS);
   wire logic       sel_bdo  = (wb_adr_in == EBPS_PORT_B_DOUT_OFS);
   wire logic       sel_bpur = (wb_adr_in == EBPS_PORT_B_PUR_OFS);
   wire logic       sel_fper = (wb_adr_in == EBPS_PORT_F_PER_OFS);
   wire logic       sel_fddr = (wb_adr_in == EBPS_PORT_F_DDR_OFS);
   wire logic       sel_fdo  = (wb_adr_in == EBPS_PORT_F_DOUT_OFS);
   wire logic       sel_fpur = (wb_adr_in == EBPS_PORT_F_PUR_OFS);
   wire logic       sel_stat = (wb_adr_in == EBPS_PIN_STATUS_OFS);
   wire logic [6:0] wf_bits  = wb_dat_in[EBPS_PF_LOW_POS +: EBPS_NUM_DATA];

   // ************************************************************
   // reset-time strap decode: address function unless plain internal boot
   // ************************************************************
   wire logic strap_addr = external_boot_select_in | (memory_interface_mode_select_in & ~flash_secure_in);

   // ************************************************************
   // single-bit registers of port B and bus control
   // ************************************************************
   ebps_sync_reg #(.RST_VAL(EBPS_IDLE_DRIVE_RST)) u_idle_drive (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_lo & sel_bc),
      .wr_dat_in   (wb_dat_in[EBPS_IDLE_DRIVE_POS]),
      .val_out     (idle_drive_q)
   );
   ebps_sync_reg #(.RST_VAL(1'h0)) u_pb_ddr (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_lo & sel_bddr),
      .wr_dat_in   (wb_dat_in[EBPS_PB_BIT0_POS]),
      .val_out     (pb_ddr_q)
   );
   ebps_sync_reg #(.RST_VAL(1'h0)) u_pb_dout (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_lo & sel_bdo),
      .wr_dat_in   (wb_dat_in[EBPS_PB_BIT0_POS]),
      .val_out     (pb_dout_q)
   );
   ebps_sync_reg #(.RST_VAL(1'h0)) u_pb_pur (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_lo & sel_bpur),
      .wr_dat_in   (wb_dat_in[EBPS_PB_BIT0_POS]),
      .val_out     (pb_pur_q)
   );

   // ************************************************************
   // port B function select: strap caught after release, software overrides
   // ************************************************************
   always_comb begin
      strap_pend_d = strap_pend_q;
      if (reset_in) begin
         strap_pend_d = 1'h1;
      end else if (strap_pend_q) begin
         strap_pend_d = 1'h0;
      end
   end
   always_ff @(posedge core_clk_in) begin
      strap_pend_q <= strap_pend_d;
      if (reset_in) begin
         pb_per_q <= 1'h0;
      end else if (wr_lo & sel_bper) begin
         pb_per_q <= wb_dat_in[EBPS_PB_BIT0_POS];
      end else if (strap_pend_q) begin
         pb_per_q <= strap_addr;
      end
   end

   // ************************************************************
   // port F registers, bits 9..15 only, one generate per data line
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < EBPS_NUM_DATA; gi++) begin : g_pf
         ebps_sync_reg #(.RST_VAL(EBPS_PORT_F_PER_RST[EBPS_PF_LOW_POS + gi])) u_per (
            .core_clk_in (core_clk_in),
            .reset_in    (reset_in),
            .wr_en_in    (wr_hi & sel_fper),
            .wr_dat_in   (wf_bits[gi]),
            .val_out     (pf_per_q[gi])
         );
         ebps_sync_reg #(.RST_VAL(1'h0)) u_ddr (
            .core_clk_in (core_clk_in),
            .reset_in    (reset_in),
            .wr_en_in    (wr_hi & sel_fddr),
            .wr_dat_in   (wf_bits[gi]),
            .val_out     (pf_ddr_q[gi])
         );
         ebps_sync_reg #(.RST_VAL(1'h0)) u_dout (
            .core_clk_in (core_clk_in),
            .reset_in    (reset_in),
            .wr_en_in    (wr_hi & sel_fdo),
            .wr_dat_in   (wf_bits[gi]),
            .val_out     (pf_dout_q[gi])
         );
         ebps_sync_reg #(.RST_VAL(1'h0)) u_pur (
            .core_clk_in (core_clk_in),
            .reset_in    (reset_in),
            .wr_en_in    (wr_hi & sel_fpur),
            .wr_dat_in   (wf_bits[gi]),
            .val_out     (pf_pur_q[gi])
         );
      end
   endgenerate

   // ************************************************************
   // pin drive decisions
   // ************************************************************
   wire logic       bus_drive = mif_bus_active_in | idle_drive_q;
   wire logic       pb_oe_d   = pb_per_q ? bus_drive : pb_ddr_q;
   wire logic       pb_val_d  = pb_per_q ? mif_addr16_in : pb_dout_q;
   wire logic [6:0] bus_d_oe  = {7{bus_drive & mif_data_oe_in}};
   wire logic [6:0] pf_oe_d   = (pf_per_q & bus_d_oe) | (~pf_per_q & pf_ddr_q);
   wire logic [6:0] pf_val_d  = (pf_per_q & mif_data_in) | (~pf_per_q & pf_dout_q);

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb begin
      rd_dat_d = 32'h0000_0000;
      if (sel_bc) begin
         rd_dat_d[EBPS_IDLE_DRIVE_POS] = idle_drive_q;
      end else if (sel_bper) begin
         rd_dat_d[EBPS_PB_BIT0_POS] = pb_per_q;
      end else if (sel_bddr) begin
         rd_dat_d[EBPS_PB_BIT0_POS] = pb_ddr_q;
      end else if (sel_bdo) begin
         rd_dat_d[EBPS_PB_BIT0_POS] = pb_dout_q;
      end else if (sel_bpur) begin
         rd_dat_d[EBPS_PB_BIT0_POS] = pb_pur_q;
      end else if (sel_fper) begin
         rd_dat_d[EBPS_PF_LOW_POS +: EBPS_NUM_DATA] = pf_per_q;
      end else if (sel_fddr) begin
         rd_dat_d[EBPS_PF_LOW_POS +: EBPS_NUM_DATA] = pf_ddr_q;
      end else if (sel_fdo) begin
         rd_dat_d[EBPS_PF_LOW_POS +: EBPS_NUM_DATA] = pf_dout_q;
      end else if (sel_fpur) begin
         rd_dat_d[EBPS_PF_LOW_POS +: EBPS_NUM_DATA] = pf_pur_q;
      end else if (sel_stat) begin
         rd_dat_d[EBPS_STAT_PB_POS]                   = port_b_bit0_pin_in;
         rd_dat_d[EBPS_STAT_PF_POS +: EBPS_NUM_DATA]  = data_line_pin_in;
         rd_dat_d[EBPS_STAT_AFN_POS]                  = pb_per_q;
         rd_dat_d[EBPS_STAT_BUSY_POS]                 = mif_bus_active_in;
      end
   end

   // ************************************************************
   // bus answer: ack one cycle after request, unmapped reads zero
   // ************************************************************
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         wb_ack_out <= 1'h0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_req;
         wb_dat_out <= wb_req ? rd_dat_d : 32'h0000_0000;
      end
   end

   // ************************************************************
   // registered pin outputs; reset: all floated, pull-ups on
   // ************************************************************
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         first_q                  <= 1'h1;
         port_b_bit0_pin_out      <= 1'h0;
         port_b_bit0_pin_oe_n_out <= 1'h1;
         port_b_bit0_pullup_out   <= 1'h1;
         data_line_pin_out        <= 7'h00;
         data_line_pin_oe_n_out   <= 7'h7f;
         data_line_pullup_out     <= 7'h7f;
         mif_data_out             <= 7'h00;
         mif_ctrl_float_out       <= 1'h1;
      end else begin
         first_q                  <= 1'h0;
         port_b_bit0_pin_out      <= pb_val_d;
         port_b_bit0_pin_oe_n_out <= ~pb_oe_d;
         port_b_bit0_pullup_out   <= ~pb_pur_q;
         data_line_pin_out        <= pf_val_d;
         data_line_pin_oe_n_out   <= ~pf_oe_d;
         data_line_pullup_out     <= ~pf_pur_q;
         mif_data_out             <= data_line_pin_in & pf_per_q;
         mif_ctrl_float_out       <= ~bus_drive;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   property p_strap_sel;
      @(posedge core_clk_in) disable iff (reset_in)
      (strap_pend_q & ~(wr_lo & sel_bper)) |=> (pb_per_q == $past(strap_addr));
   endproperty
   a_strap_sel: assert property (p_strap_sel) else $error("strap selection not applied");

   property p_per_write;
      @(posedge core_clk_in) disable iff (reset_in)
      (wr_lo & sel_bper) |=> (pb_per_q == $past(wb_dat_in[0]));
   endproperty
   a_per_write: assert property (p_per_write) else $error("port B function write lost");

   property p_addr_float;
      @(posedge core_clk_in) disable iff (reset_in)
      (pb_per_q & ~mif_bus_active_in & ~idle_drive_q) |=> port_b_bit0_pin_oe_n_out;
   endproperty
   a_addr_float: assert property (p_addr_float) else $error("address line driven while idle");

   property p_data_float;
      @(posedge core_clk_in) disable iff (reset_in)
      (~mif_bus_active_in & ~idle_drive_q) |=> ((~data_line_pin_oe_n_out & $past(pf_per_q)) == 7'h00);
   endproperty
   a_data_float: assert property (p_data_float) else $error("data lines driven while idle");

   property p_pb_pullup;
      @(posedge core_clk_in) disable iff (reset_in)
      pb_pur_q |=> ~port_b_bit0_pullup_out;
   endproperty
   a_pb_pullup: assert property (p_pb_pullup) else $error("port B pull-up not disabled");

   property p_reset_data_fn;
      @(posedge core_clk_in)
      $fell(reset_in) |-> (pf_per_q == 7'h7f);
   endproperty
   a_reset_data_fn: assert property (p_reset_data_fn) else $error("data function not default");

   property p_pf_dir;
      @(posedge core_clk_in) disable iff (reset_in || first_q)
      (~pf_per_q[0]) |=> (data_line_pin_oe_n_out[0] == ~$past(pf_ddr_q[0]));
   endproperty
   a_pf_dir: assert property (p_pf_dir) else $error("port F direction not honoured");

   property p_pf_pullup;
      @(posedge core_clk_in) disable iff (reset_in)
      (pf_pur_q[6]) |=> ~data_line_pullup_out[6];
   endproperty
   a_pf_pullup: assert property (p_pf_pullup) else $error("port F pull-up not disabled");

   property p_pb_gpio;
      @(posedge core_clk_in) disable iff (reset_in)
      (~pb_per_q & pb_ddr_q) |=> (~port_b_bit0_pin_oe_n_out && port_b_bit0_pin_out == $past(pb_dout_q));
   endproperty
   a_pb_gpio: assert property (p_pb_gpio) else $error("port B output not driven");

   property p_wb_ack;
      @(posedge core_clk_in) disable iff (reset_in)
      wb_req |=> wb_ack_out ##1 ~wb_ack_out;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

   c_override: cover property (@(posedge core_clk_in) disable iff (reset_in) wr_lo & sel_bper);
   c_idle_drive: cover property (@(posedge core_clk_in) disable iff (reset_in) idle_drive_q & ~mif_bus_active_in);
   c_pf_gpio: cover property (@(posedge core_clk_in) disable iff (reset_in) ~pf_per_q[3] & pf_ddr_q[3]);
endmodule
`default_nettype wire

// file: ebps_mem_model.sv
// far-side model: memory and board wiring that resolve the shared pins
`timescale 1ns/1ps
`default_nettype none
module ebps_mem_model
   import ebps_pkg::*;
#(
   parameter int W = 8
) (
   // clock
   input  wire logic         core_clk_in,
   // levels, enables and pull-ups from the pin logic
   input  wire logic [W-1:0] pin_out_in,
   input  wire logic [W-1:0] pin_oe_n_in,
   input  wire logic [W-1:0] pullup_in,
   // memory read data put on the lines
   input  wire logic [W-1:0] mem_drive_in,
   input  wire logic [W-1:0] mem_val_in,
   // resolved wire levels
   output var  logic [W-1:0] pin_level_out
);
   logic [W-1:0] last_q = '0;
   // pin logic first, then memory, then pull-up; a floating line wanders every cycle
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!pin_oe_n_in[i]) pin_level_out[i] = pin_out_in[i];
         else if (mem_drive_in[i]) pin_level_out[i] = mem_val_in[i];
         else if (pullup_in[i]) pin_level_out[i] = 1'b1;
         else pin_level_out[i] = ~last_q[i];
      end
   end
   // remember the level so a floating line never shows a stale value
   always @(posedge core_clk_in) begin
      last_q <= pin_level_out;
   end
endmodule
`default_nettype wire

// file: ebps_top_test.sv
// self-checking testbench for the pin sharing block
`timescale 1ns/1ps
`default_nettype none
module ebps_top_test
   import ebps_pkg::*;
;
   // ************************************************************
   // signals
   // ************************************************************
   logic            core_clk_in = 1'b0;
   logic            reset_in    = 1'b1;
   ebps_wb_req_type req         = '0;
   logic [31:0]     wb_dat_out, rd;
   logic            wb_ack_out;
   logic [2:0]      strap       = 3'h0;   // boot, mode, secure
   logic            bus_act     = 1'b0;
   logic            hi_addr     = 1'b0;
   logic            mif_doe     = 1'b0;
   logic [6:0]      mif_wdat    = 7'h00;
   logic [6:0]      mif_data_out, dl_out, dl_oe_n, dl_pu, dl_in;
   logic            mif_ctrl_float_out, pb_in, pb_out, pb_oe_n, pb_pu;
   logic [7:0]      mem_drive   = 8'h00;
   logic [7:0]      mem_val     = 8'h00;
   int              num_errors  = 0;
   int              num_checks  = 0;

   // clock
   always #10 core_clk_in = ~core_clk_in;

   // design and far side
   ebps_top i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .wb_cyc_in(req.cyc), .wb_stb_in(req.stb),
      .wb_we_in(req.we), .wb_sel_in(req.sel), .wb_adr_in(req.adr), .wb_dat_in(req.dat), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .external_boot_select_in(strap[2]), .memory_interface_mode_select_in(strap[1]),
      .flash_secure_in(strap[0]), .mif_bus_active_in(bus_act), .mif_addr16_in(hi_addr), .mif_data_oe_in(mif_doe),
      .mif_data_in(mif_wdat), .mif_data_out(mif_data_out), .mif_ctrl_float_out(mif_ctrl_float_out),
      .port_b_bit0_pin_in(pb_in), .port_b_bit0_pin_out(pb_out), .port_b_bit0_pin_oe_n_out(pb_oe_n),
      .port_b_bit0_pullup_out(pb_pu), .data_line_pin_in(dl_in), .data_line_pin_out(dl_out),
      .data_line_pin_oe_n_out(dl_oe_n), .data_line_pullup_out(dl_pu));
   ebps_mem_model #(.W(8)) i_mem (.core_clk_in(core_clk_in), .pin_out_in({dl_out, pb_out}),
      .pin_oe_n_in({dl_oe_n, pb_oe_n}), .pullup_in({dl_pu, pb_pu}), .mem_drive_in(mem_drive),
      .mem_val_in(mem_val), .pin_level_out({dl_in, pb_in}));

   // ************************************************************
   // helpers
   // ************************************************************
   // verdict and end of run
   task automatic summarize;
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      @(posedge core_clk_in);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      rd = wb_dat_out;
      if (wb_ack_out !== 1'b1) chk(32'h0, 32'h1, "no ack");
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat, 4'hf);
   endtask
   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, 4'hf);
      chk(rd, exp, "read data");
   endtask
   // let registered pins follow, then look between edges
   task automatic settle;
      repeat (2) @(posedge core_clk_in);
      @(negedge core_clk_in);
   endtask
   // reset held 10 cycles, pins checked while it is held
   task automatic do_reset;
      @(posedge core_clk_in);
      reset_in <= 1'b1;
      repeat (10) @(posedge core_clk_in);
      @(negedge core_clk_in);
      chk({dl_oe_n, pb_oe_n, dl_pu, pb_pu, mif_ctrl_float_out}, 17'h1ffff, "pins in reset");
      @(posedge core_clk_in);
      reset_in <= 1'b0;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      do_reset();
      rdchk(EBPS_PORT_F_PER_OFS, 32'h0000fe00);
      rdchk(EBPS_BUS_CONTROL_OFS, 32'h0);
      rdchk(EBPS_PORT_F_DDR_OFS, 32'h0);
      rdchk(8'h30, 32'h0);
      settle();
      chk({mif_ctrl_float_out, dl_oe_n}, 8'hff, "idle float");
   endtask
   // every strap combination selects the reset-time function
   task automatic t_strap;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk_in);
         strap <= 3'(i);
         do_reset();
         wb(1'b0, EBPS_PIN_STATUS_OFS, 32'h0, 4'hf);
         chk(rd[EBPS_STAT_AFN_POS], strap[2] | (strap[1] & ~strap[0]), "strap function");
      end
   endtask
   // port function on port_b_bit0, bus traffic must not reach it
   task automatic t_pb;
      wr(EBPS_PORT_B_PER_OFS, 32'h0);
      bus_act <= 1'b1;
      wr(EBPS_PORT_B_DDR_OFS, 32'h1);
      wr(EBPS_PORT_B_DOUT_OFS, 32'h1);
      settle();
      chk({pb_oe_n, pb_out}, 2'h1, "pb out high");
      wr(EBPS_PORT_B_DOUT_OFS, 32'h0);
      settle();
      chk({pb_oe_n, pb_out}, 2'h0, "pb out low");
      wr(EBPS_PORT_B_DDR_OFS, 32'h0);
      settle();
      wb(1'b0, EBPS_PIN_STATUS_OFS, 32'h0, 4'hf);
      chk({pb_oe_n, rd[EBPS_STAT_PB_POS], rd[EBPS_STAT_AFN_POS]}, 3'h6, "pb input");
      wr(EBPS_PORT_B_PUR_OFS, 32'h1);
      settle();
      chk(pb_pu, 1'b0, "pb pull-up off");
      wr(EBPS_PORT_B_PUR_OFS, 32'h0);
   endtask
   // address line 16 with idle float and drive bit
   task automatic t_addr;
      wr(EBPS_PORT_B_PER_OFS, 32'h1);
      bus_act <= 1'b0;
      settle();
      chk({pb_oe_n, mif_ctrl_float_out}, 2'h3, "address idle float");
      @(posedge core_clk_in);
      bus_act <= 1'b1;
      hi_addr <= 1'b1;
      settle();
      chk({pb_oe_n, pb_out}, 2'h1, "address high");
      @(posedge core_clk_in);
      hi_addr <= 1'b0;
      settle();
      chk({pb_oe_n, pb_out}, 2'h0, "address low");
      @(posedge core_clk_in);
      bus_act <= 1'b0;
      wr(EBPS_BUS_CONTROL_OFS, 32'h1);
      settle();
      chk({pb_oe_n, mif_ctrl_float_out}, 2'h0, "address idle driven");
      wr(EBPS_BUS_CONTROL_OFS, 32'h0);
   endtask
   // data lines in bus function: write, idle, read
   task automatic t_data;
      bus_act <= 1'b1;
      mif_doe <= 1'b1;
      mif_wdat <= 7'h55;
      settle();
      chk({dl_oe_n, dl_out}, 14'h0055, "data write");
      @(posedge core_clk_in);
      bus_act <= 1'b0;
      settle();
      chk(dl_oe_n, 7'h7f, "data idle float");
      wr(EBPS_BUS_CONTROL_OFS, 32'h1);
      settle();
      chk(dl_oe_n, 7'h00, "data idle driven");
      wr(EBPS_BUS_CONTROL_OFS, 32'h0);
      bus_act <= 1'b1;
      mif_doe <= 1'b0;
      mem_drive <= 8'hfe;
      mem_val <= 8'h54;
      settle();
      chk({dl_oe_n, mif_data_out}, 14'h3faa, "data read");
      @(posedge core_clk_in);
      mem_drive <= 8'h00;
   endtask
   // port F bits, mixed functions and directions
   task automatic t_portf;
      mif_doe <= 1'b1;
      mif_wdat <= 7'h7f;
      wr(EBPS_PORT_F_PER_OFS, 32'h0e00);
      settle();
      chk(dl_oe_n, 7'h78, "mixed function");
      wr(EBPS_PORT_F_PER_OFS, 32'h0);
      wr(EBPS_PORT_F_DOUT_OFS, 32'h0000fe00);
      wr(EBPS_PORT_F_DDR_OFS, 32'h0000aa00);
      settle();
      chk({dl_oe_n, dl_out & 7'h55, mif_data_out}, 21'haaa80, "port f pins");
      for (int n = 0; n < 7; n++) begin
         wr(EBPS_PORT_F_PUR_OFS, 32'h1 << (EBPS_PF_LOW_POS + n));
         settle();
         chk(dl_pu, 7'h7f ^ (7'h01 << n), "port f pull-up");
      end
      wr(EBPS_PORT_F_PUR_OFS, 32'h0);
      wb(1'b1, EBPS_PORT_F_PUR_OFS, 32'h0000fe00, 4'hd);
      settle();
      chk(dl_pu, 7'h7f, "masked byte ignored");
   endtask

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      t_reset();
      t_strap();
      t_pb();
      t_addr();
      t_data();
      t_portf();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
